// [hdl/smz_cmd_unit.sv]
// Command interpreter for user-zone and system commands of a secure memory
`timescale 1ns/10ps
module smz_cmd_unit
   import smz_pkg::*;
#(
   parameter int PAGE_BYTES = 16,
   parameter int ZONE_BYTES = 128,
   parameter int FIFO_DEPTH = 32,
   parameter int WR_CYC     = WR_CYCLES
) (
   input  wire logic        clk_i,          // Clock, 100 MHz
   input  wire logic        rst_i,          // Async reset, active high
   input  wire logic [7:0]  rx_data_i,      // Received character
   input  wire logic        rx_valid_i,     // Received character strobe
   output logic [7:0]       tx_data_o,      // Character to send
   output logic             tx_valid_o,     // Character offer
   input  wire logic        tx_ready_i,     // Transmitter accepts character
   input  wire logic        wr_right_i,     // Host may write selected zone
   input  wire logic        rd_right_i,     // Host may read selected zone
   input  wire logic        auth_needed_i,  // Zone writes need checksum
   input  wire logic        cfg_ok_i,       // Config address authorized
   input  wire logic        secure_code_ok_i, // Secure code presented
   input  wire logic        cksum_ok_i,     // Received checksum valid
   output logic             auth_revoke_o,  // Clear authentication privilege
   output logic [15:0]      mem_addr_o,     // Address for config right lookup / read
   output logic             mem_cfg_o,      // Addressing config memory
   input  wire logic [7:0]  mem_rdata_i,    // Read data at mem_addr_o
   output logic             mem_we_o,       // Write one byte strobe
   output smz_mem_t         mem_wr_o,       // Byte written
   output logic             mem_at_o,       // Write in anti-tearing mode
   output logic [3:0]       zone_o,         // Selected zone
   output logic [15:0]      cksum_o,        // Checksum for readback
   output logic [7:0]       security_fuse_state_o // Fuse byte
);
   initial begin
      if (PAGE_BYTES < 1 || PAGE_BYTES > FIFO_DEPTH) $error("smz_cmd_unit: bad PAGE_BYTES");
      if (ZONE_BYTES < 2 || ZONE_BYTES > 65536) $error("smz_cmd_unit: bad ZONE_BYTES");
   end

   typedef enum logic [3:0] {
      S_HDR, S_DEC, S_PROC, S_RXDATA, S_WAITCK, S_CYCLE, S_DRAIN,
      S_TXDATA, S_SW1, S_SW2
   } smz_state_t;

   smz_state_t  st;
   smz_state_t  next_st;
   smz_hdr_t    hdr;
   smz_hdr_t    next_hdr;
   logic [1:0]  hcnt;
   logic [1:0]  next_hcnt;
   logic [8:0]  cnt;
   logic [8:0]  next_cnt;
   logic [15:0] addr;
   logic [15:0] next_addr;
   logic [7:0]  sw1;
   logic [7:0]  next_sw1;
   logic        bad;
   logic        next_bad;
   logic [3:0]  zone;
   logic [3:0]  next_zone;
   logic        zone_at;
   logic        next_zone_at;
   logic [7:0]  fuses;
   logic [7:0]  next_fuses;
   logic [15:0] cksum;
   logic [15:0] next_cksum;
   logic [31:0] tmr;
   logic [31:0] next_tmr;
   logic        is_cfg;
   logic        next_is_cfg;
   logic        ck_lo;
   logic        next_ck_lo;
   logic [7:0]  tx_byte;
   logic        f_in_valid;
   logic        f_in_ready;
   logic [7:0]  f_out;
   logic        f_out_valid;
   logic        f_pop;
   logic        f_clr;
   logic        ck_cmd;

   // Zero means 256 bytes on user and config data commands, incoming or outgoing
   function automatic logic [8:0] len_of(input logic [7:0] p3);
      return (p3 == 8'h00) ? LEN_256 : {1'b0, p3};
   endfunction

   // Next address inside the selected zone, rolling over at its end
   function automatic logic [15:0] wrap_inc(input logic [15:0] a);
      return (a == 16'(ZONE_BYTES - 1)) ? 16'h0000 : a + 16'h0001;
   endfunction

   smz_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .clr_i      (f_clr),
      .in_data_i  (rx_data_i),
      .in_valid_i (f_in_valid),
      .in_ready_o (f_in_ready),
      .out_data_o (f_out),
      .out_valid_o(f_out_valid),
      .out_ready_i(f_pop)
   );

   always_comb begin
      next_st      = st;
      next_hdr     = hdr;
      next_hcnt    = hcnt;
      next_cnt     = cnt;
      next_addr    = addr;
      next_sw1     = sw1;
      next_bad     = bad;
      next_zone    = zone;
      next_zone_at = zone_at;
      next_fuses   = fuses;
      next_cksum   = cksum;
      next_tmr     = tmr;
      next_is_cfg  = is_cfg;
      next_ck_lo   = ck_lo;
      tx_byte      = 8'h00;
      tx_valid_o   = 1'b0;
      f_in_valid   = 1'b0;
      f_pop        = 1'b0;
      f_clr        = 1'b0;
      mem_we_o     = 1'b0;
      auth_revoke_o = 1'b0;
      ck_cmd        = (hdr.ins == INS_SYS_WR) && (hdr.p1 == P1_CKSUM);
      case (st)
         S_HDR: begin
            if (rx_valid_i) begin
               case (hcnt)
                  2'd0: next_hdr.ins = rx_data_i;
                  2'd1: next_hdr.p1  = rx_data_i;
                  2'd2: next_hdr.p2  = rx_data_i;
                  default: next_hdr.p3 = rx_data_i;
               endcase
               next_hcnt = hcnt + 2'd1;
               if (hcnt == 2'd3) begin
                  next_st = S_DEC;
               end
            end
         end
         S_DEC: begin
            // Class byte is not examined; the first header byte is the instruction
            next_cnt    = len_of(hdr.p3);
            next_bad    = 1'b0;
            next_is_cfg = 1'b0;
            next_sw1    = SW_OK;
            next_st     = S_PROC;
            // A write held for its checksum keeps its bytes and start address
            if (!ck_cmd) begin
               next_addr = {hdr.p1, hdr.p2};
               f_clr     = 1'b1;
            end
            case (hdr.ins)
               INS_WR_USER: begin
                  if (!wr_right_i) next_sw1 = SW_UNAUTH;
               end
               INS_RD_USER: begin
                  if (!rd_right_i) next_sw1 = SW_UNAUTH;
               end
               INS_SYS_WR: begin
                  case (hdr.p1)
                     P1_CFG, P1_CFG_AT: begin
                        next_is_cfg = 1'b1;
                        next_addr   = {8'h00, hdr.p2};
                     end
                     P1_FUSE, P1_SETZONE, P1_SETZ_AT: begin
                        if (hdr.p3 != 8'h00) next_sw1 = SW_LEN;
                     end
                     P1_CKSUM: begin
                        if (hdr.p3 != CK_LEN) next_sw1 = SW_LEN;
                     end
                     default: next_sw1 = SW_ADDR;
                  endcase
               end
               INS_SYS_RD: begin
                  case (hdr.p1)
                     P1_CFG: begin
                        next_is_cfg = 1'b1;
                        next_addr   = {8'h00, hdr.p2};
                     end
                     P1_FUSE: begin
                        if (hdr.p3 != FUSE_LEN) next_sw1 = SW_LEN;
                     end
                     P1_CKSUM: begin
                        if (hdr.p3 != CK_LEN) next_sw1 = SW_LEN;
                     end
                     default: next_sw1 = SW_ADDR;
                  endcase
               end
               default: next_sw1 = SW_BADINS;
            endcase
         end
         S_PROC: begin
            // Config right of the start address is looked up here
            if (is_cfg && !cfg_ok_i) begin
               next_sw1 = SW_UNAUTH;
               next_st  = S_SW1;
            end else if (sw1 != SW_OK) begin
               next_st = S_SW1;
            end else if (hdr.ins == INS_SYS_WR && hdr.p1 == P1_FUSE && !(secure_code_ok_i &&
                         (hdr.p2 == FUSE_ID_FIRST ||
                          (hdr.p2 == FUSE_ID_SECOND && !fuses[FB_FIRST]) ||
                          (hdr.p2 == FUSE_ID_THIRD && !fuses[FB_SECOND])))) begin
               next_sw1 = SW_UNAUTH;
               next_st  = S_SW1;
            end else begin
               // Echo the instruction as procedure byte, also for commands without data
               tx_byte    = hdr.ins;
               tx_valid_o = 1'b1;
               next_ck_lo = 1'b0;
               if (tx_ready_i) begin
                  next_st = (hdr.ins == INS_RD_USER || hdr.ins == INS_SYS_RD) ? S_TXDATA
                                                                             : S_RXDATA;
                  if (hdr.ins == INS_SYS_WR && hdr.p1 == P1_FUSE) begin
                     next_st = S_SW1;
                     if (hdr.p2 == FUSE_ID_FIRST) next_fuses[FB_FIRST] = 1'b0;
                     if (hdr.p2 == FUSE_ID_SECOND) next_fuses[FB_SECOND] = 1'b0;
                     if (hdr.p2 == FUSE_ID_THIRD) next_fuses[FB_THIRD] = 1'b0;
                  end else if (hdr.ins == INS_SYS_WR &&
                               (hdr.p1 == P1_SETZONE || hdr.p1 == P1_SETZ_AT)) begin
                     next_zone    = hdr.p2[3:0];
                     next_zone_at = (hdr.p1 == P1_SETZ_AT);
                     next_st      = S_SW1;
                  end
               end
            end
         end
         S_RXDATA: begin
            // Data waits in the FIFO so no byte is written before all rights are known
            f_in_valid = rx_valid_i && !ck_cmd;
            if (rx_valid_i && (f_in_ready || ck_cmd)) begin
               if (ck_cmd) next_cksum = {cksum[7:0], rx_data_i};
               if (is_cfg && !cfg_ok_i) next_bad = 1'b1;
               if (is_cfg) next_addr = addr + 16'h0001;
               next_cnt = cnt - 9'd1;
               if (cnt == 9'd1 && ck_cmd) begin
                  // Only a valid checksum releases the held write
                  next_st = cksum_ok_i ? S_DRAIN : S_SW1;
                  if (!cksum_ok_i) begin
                     next_sw1      = SW_UNAUTH;
                     auth_revoke_o = 1'b1;
                     f_clr         = 1'b1;
                  end
               end else if (cnt == 9'd1) begin
                  next_addr = is_cfg ? {8'h00, hdr.p2} : {hdr.p1, hdr.p2};
                  if (is_cfg && (bad || !cfg_ok_i)) begin
                     next_sw1 = SW_UNAUTH;
                     next_st  = S_SW1;
                  end else if (!is_cfg && auth_needed_i) begin
                     next_sw1 = SW_WAIT_CK;
                     next_st  = S_SW1;
                  end else begin
                     next_st = S_DRAIN;
                  end
               end
            end
         end
         S_DRAIN: begin
            // Bytes move from FIFO into the page buffer in order
            f_pop    = f_out_valid;
            mem_we_o = f_out_valid;
            if (f_out_valid) begin
               next_addr = is_cfg ? addr + 16'h0001 : wrap_inc(addr);
            end else begin
               next_tmr = 32'(WR_CYC);
               next_st  = S_CYCLE;
            end
         end
         S_CYCLE: begin
            next_tmr = tmr - 32'd1;
            if (tmr <= 32'd1) next_st = S_SW1;
         end
         S_TXDATA: begin
            tx_valid_o = 1'b1;
            if (hdr.ins == INS_SYS_RD && hdr.p1 == P1_FUSE) begin
               tx_byte = fuses;
            end else if (hdr.ins == INS_SYS_RD && hdr.p1 == P1_CKSUM) begin
               tx_byte = ck_lo ? cksum[7:0] : cksum[15:8];
            end else if (is_cfg && !cfg_ok_i) begin
               tx_byte = fuses;
            end else begin
               tx_byte = mem_rdata_i;
            end
            if (tx_ready_i) begin
               if (is_cfg && !cfg_ok_i) next_sw1 = SW_UNAUTH;
               next_ck_lo = 1'b1;
               next_addr  = is_cfg ? addr + 16'h0001 : wrap_inc(addr);
               next_cnt   = cnt - 9'd1;
               if (cnt == 9'd1) next_st = S_SW1;
            end
         end
         S_SW1: begin
            tx_byte    = sw1;
            tx_valid_o = 1'b1;
            if (tx_ready_i) next_st = S_SW2;
         end
         S_SW2: begin
            tx_byte    = SW2_ZERO;
            tx_valid_o = 1'b1;
            if (tx_ready_i) begin
               next_st   = S_HDR;
               next_hcnt = 2'd0;
            end
         end
         default: next_st = S_HDR;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st      <= S_HDR;
         hdr     <= '0;
         hcnt    <= 2'd0;
         cnt     <= 9'd0;
         addr    <= 16'h0000;
         sw1     <= SW_OK;
         bad     <= 1'b0;
         zone    <= 4'h0;
         zone_at <= 1'b0;
         fuses   <= FUSE_RESET;
         cksum   <= 16'h0000;
         tmr     <= 32'h0000_0000;
         is_cfg  <= 1'b0;
         ck_lo   <= 1'b0;
         tx_data_o <= 8'h00;
      end else begin
         st      <= next_st;
         hdr     <= next_hdr;
         hcnt    <= next_hcnt;
         cnt     <= next_cnt;
         addr    <= next_addr;
         sw1     <= next_sw1;
         bad     <= next_bad;
         zone    <= next_zone;
         zone_at <= next_zone_at;
         fuses   <= next_fuses;
         cksum   <= next_cksum;
         tmr     <= next_tmr;
         is_cfg  <= next_is_cfg;
         ck_lo   <= next_ck_lo;
         tx_data_o <= next_st == S_HDR ? 8'h00 : tx_byte;
      end
   end

   always_comb begin
      mem_addr_o            = addr;
      mem_cfg_o             = is_cfg;
      mem_wr_o.cfg          = is_cfg;
      mem_wr_o.zone         = zone;
      mem_wr_o.addr         = addr;
      mem_wr_o.data         = f_out;
      mem_at_o              = is_cfg ? (hdr.p1 == P1_CFG_AT) : zone_at;
      zone_o                = zone;
      cksum_o               = cksum;
      security_fuse_state_o = fuses;
   end
endmodule

// [hdl/smz_pkg.sv]
// Package of constants and types for the secure memory zone command unit
package smz_pkg;
   // Instruction codes
   localparam logic [7:0] INS_WR_USER = 8'hB0;
   localparam logic [7:0] INS_RD_USER = 8'hB2;
   localparam logic [7:0] INS_SYS_WR  = 8'hB4;
   localparam logic [7:0] INS_SYS_RD  = 8'hB6;
   // System write parameters
   localparam logic [7:0] P1_CFG      = 8'h00;
   localparam logic [7:0] P1_FUSE     = 8'h01;
   localparam logic [7:0] P1_CKSUM    = 8'h02;
   localparam logic [7:0] P1_SETZONE  = 8'h03;
   localparam logic [7:0] P1_CFG_AT   = 8'h08;
   localparam logic [7:0] P1_SETZ_AT  = 8'h0B;
   // Fuse identifiers
   localparam logic [7:0] FUSE_ID_FIRST  = 8'h06;
   localparam logic [7:0] FUSE_ID_SECOND = 8'h04;
   localparam logic [7:0] FUSE_ID_THIRD  = 8'h00;
   // Fuse byte field positions
   localparam int FB_FIRST  = 0;
   localparam int FB_SECOND = 1;
   localparam int FB_THIRD  = 2;
   localparam int FB_SEC    = 3;
   localparam logic [7:0] FUSE_RESET = 8'h0F;
   // Status bytes and lengths
   localparam logic [7:0] SW_WAIT_CK = 8'h62;
   localparam logic [7:0] SW_LEN     = 8'h67;
   localparam logic [7:0] SW_UNAUTH  = 8'h69;
   localparam logic [7:0] SW_ADDR    = 8'h6B;
   localparam logic [7:0] SW_BADINS  = 8'h6D;
   localparam logic [7:0] SW_OK      = 8'h90;
   localparam logic [7:0] SW2_ZERO   = 8'h00;
   localparam logic [7:0] AT_MAX_LEN = 8'h08;
   localparam logic [7:0] CK_LEN     = 8'h02;
   localparam logic [7:0] FUSE_LEN   = 8'h01;
   localparam logic [8:0] LEN_256    = 9'h100;
   // Self-timed write cycle
   localparam int WR_TIME_US  = 5000;
   localparam int CLK_MHZ     = 100;
   localparam int WR_CYCLES   = WR_TIME_US * CLK_MHZ;

   typedef struct packed {
      logic [7:0] ins;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] p3;
   } smz_hdr_t;

   // Memory access request toward the EEPROM array
   typedef struct packed {
      logic       cfg;    // 1: configuration memory, 0: user zone
      logic [3:0] zone;
      logic [15:0] addr;
      logic [7:0] data;
   } smz_mem_t;
endpackage

// [hdl/smz_fifo.sv]
// Synchronous FIFO holding write data between link and EEPROM page buffer
`timescale 1ns/10ps
module smz_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_i,     // Clock
   input  wire logic             rst_i,     // Async reset
   input  wire logic             clr_i,     // Flush contents
   input  wire logic [WIDTH-1:0] in_data_i, // Fill data
   input  wire logic             in_valid_i,// Fill valid
   output logic                  in_ready_o,// Not full
   output logic [WIDTH-1:0]      out_data_o,// Head data
   output logic                  out_valid_o,// Not empty
   input  wire logic             out_ready_i // Drain
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("smz_fifo: DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp;
   logic [AW:0]      rp;
   logic [AW:0]      next_wp;
   logic [AW:0]      next_rp;
   logic             push;
   logic             pop;

   always_comb begin
      in_ready_o  = (wp - rp) != (AW+1)'(DEPTH);
      out_valid_o = wp != rp;
      out_data_o  = mem[rp[AW-1:0]];
      push        = in_valid_i && in_ready_o;
      pop         = out_valid_o && out_ready_i;
      next_wp     = clr_i ? '0 : (push ? wp + 1'b1 : wp);
      next_rp     = clr_i ? '0 : (pop ? rp + 1'b1 : rp);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp <= '0;
         rp <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp[AW-1:0]] <= in_data_i;
      end
   end
endmodule

// [verif/smz_monitor.sv]
// Port checker for the command unit, bound to the top module
`timescale 1ns/10ps
module smz_monitor
   import smz_pkg::*;
(
   input wire logic       clk_i,                 // Clock
   input wire logic       rst_i,                 // Reset
   input wire logic [7:0] tx_data_o,             // Char out
   input wire logic       tx_valid_o,            // Offer
   input wire logic       tx_ready_i,            // Accept
   input wire logic       wr_right_i,            // Write right
   input wire logic       secure_code_ok_i,      // Secure code
   input wire logic       cksum_ok_i,            // Checksum good
   input wire logic       auth_revoke_o,         // Revoke
   input wire logic       mem_we_o,              // Write strobe
   input wire smz_mem_t   mem_wr_o,              // Write record
   input wire logic [3:0] zone_o,                // Zone
   input wire logic [7:0] security_fuse_state_o  // Fuses
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Named sequences
   // ----------------------------------------
   sequence s_pend;
      tx_valid_o && !tx_ready_i;
   endsequence
   sequence s_two_wr;
      mem_we_o ##1 mem_we_o;
   endsequence
   a_offer_holds: assert property (s_pend |=> tx_valid_o)
      else $error("offer withdrawn");
   a_data_stable: assert property (s_pend ##1 s_pend |=> $stable(tx_data_o))
      else $error("offered char changed");
   a_quiet_reset: assert property (disable iff (1'b0) rst_i |-> !tx_valid_o && !mem_we_o)
      else $error("activity in reset");
   a_wr_next_addr: assert property (s_two_wr |-> mem_wr_o.addr == $past(mem_wr_o.addr) + 1)
      else $error("write address not sequential");
   a_wr_zone: assert property (mem_we_o && !mem_wr_o.cfg |-> mem_wr_o.zone == zone_o)
      else $error("write to wrong zone");
   a_wr_right: assert property (mem_we_o && !mem_wr_o.cfg |-> wr_right_i)
      else $error("write without right");
   a_fuse_oneway: assert property ($changed(security_fuse_state_o) |-> secure_code_ok_i &&
      ((security_fuse_state_o[3:0] & ~$past(security_fuse_state_o[3:0])) == 4'h0))
      else $error("fuse set or blown without code");
   a_fuse_order: assert property ($fell(security_fuse_state_o[FB_SECOND])
      |-> !security_fuse_state_o[FB_FIRST] ##0 1) else $error("fuse order broken");
   a_fuse_third: assert property ($fell(security_fuse_state_o[FB_THIRD])
      |-> !security_fuse_state_o[FB_SECOND]) else $error("third fuse early");
   a_fuse_resv: assert property (security_fuse_state_o[7:4] == FUSE_RESET[7:4])
      else $error("reserved fuse bits moved");
   a_revoke_bad: assert property (auth_revoke_o |-> !cksum_ok_i)
      else $error("revoke on good checksum");
endmodule
bind smz_cmd_unit smz_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .tx_data_o(tx_data_o),
   .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .wr_right_i(wr_right_i),
   .secure_code_ok_i(secure_code_ok_i), .cksum_ok_i(cksum_ok_i),
   .auth_revoke_o(auth_revoke_o), .mem_we_o(mem_we_o), .mem_wr_o(mem_wr_o),
   .zone_o(zone_o), .security_fuse_state_o(security_fuse_state_o));

// [verif/smz_host_model.sv]
// Host terminal model on the character link
`timescale 1ns/10ps
module smz_host_model (
   input  wire logic       clk_i,      // Clock
   output logic [7:0]      rx_data_o,  // Char to device
   output logic            rx_valid_o, // Char strobe
   input  wire logic [7:0] tx_data_i,  // Char from device
   input  wire logic       tx_valid_i, // Device offer
   output logic            tx_ready_o  // Accept
);
   int stall = 0;
   initial begin
      rx_data_o = 8'h00;
      rx_valid_o = 1'b0;
      tx_ready_o = 1'b0;
   end
   task automatic send(input logic [7:0] b);
      @(posedge clk_i);
      #1 rx_data_o = b;
      rx_valid_o = 1'b1;
      @(posedge clk_i);
      #1 rx_valid_o = 1'b0;
      rx_data_o = ~b; // Released line must not keep the last char
   endtask
   // Ready stays low in the first offer cycle: the char lands a cycle late
   task automatic recv(output logic [7:0] b);
      int n;
      n = 0;
      b = 8'hxx;
      do begin
         @(posedge clk_i);
         #1 n++;
      end while (tx_valid_i !== 1'b1 && n < 3000);
      repeat (stall) @(posedge clk_i);
      @(posedge clk_i);
      #1 tx_ready_o = 1'b1;
      @(posedge clk_i);
      b = tx_data_i;
      #1 tx_ready_o = 1'b0;
   endtask
endmodule

// [verif/smz_cmd_unit_bench.sv]
// Self-checking bench for the command unit
`timescale 1ns/10ps
module smz_cmd_unit_bench;
   import smz_pkg::*;
   logic        clk_i, rst_i, rxv, txv, txr, rev, mcfg, we, at, cok, wrr, rdr, au, sec, ck;
   logic [7:0]  rxd, txd, mrd, fuse;
   logic [8:0]  lim;
   logic [15:0] ma, cko;
   logic [3:0]  zone;
   smz_mem_t    wr;
   smz_mem_t    wq[$];
   logic        atq[$];
   logic [7:0]  cmem[256];
   int          n_errors = 0;
   int          n_compared = 0;
   int          nrev = 0;
   always #5 clk_i = ~clk_i;
   // User zone content follows the whole low address byte, so a missed wrap shows
   assign mrd = mcfg ? cmem[ma[7:0]] : (8'hA5 ^ ma[7:0]);
   assign cok = {1'b0, ma[7:0]} < lim;
   initial foreach (cmem[i]) cmem[i] = ~8'(i);
   always @(negedge clk_i) begin
      if (we) begin
         wq.push_back(wr);
         atq.push_back(at);
         if (wr.cfg) cmem[wr.addr[7:0]] = wr.data;
      end
      if (rev) nrev++;
   end
   smz_cmd_unit #(.ZONE_BYTES(16), .WR_CYC(10)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .rx_data_i(rxd), .rx_valid_i(rxv), .tx_data_o(txd), .tx_valid_o(txv),
      .tx_ready_i(txr), .wr_right_i(wrr), .rd_right_i(rdr), .auth_needed_i(au),
      .cfg_ok_i(cok), .secure_code_ok_i(sec), .cksum_ok_i(ck), .auth_revoke_o(rev),
      .mem_addr_o(ma), .mem_cfg_o(mcfg), .mem_rdata_i(mrd), .mem_we_o(we),
      .mem_wr_o(wr), .mem_at_o(at), .zone_o(zone), .cksum_o(cko),
      .security_fuse_state_o(fuse));
   smz_host_model host (.clk_i(clk_i), .rx_data_o(rxd), .rx_valid_o(rxv),
      .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkw(smz_mem_t e, smz_mem_t g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("Error mem_wr expected %h seen %h", e, g);
      end
   endtask
   task automatic xp(logic [7:0] e);
      logic [7:0] b;
      host.recv(b);
      chk8("tx_data", e, b);
   endtask
   task automatic sw(logic [7:0] e);
      xp(e);
      xp(SW2_ZERO);
   endtask
   task automatic cmd(logic [7:0] i, logic [7:0] a, logic [7:0] b, logic [7:0] c);
      host.send(i);
      host.send(a);
      host.send(b);
      host.send(c);
      wq.delete();
      atq.delete();
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_tear();
      cmd(INS_SYS_WR, P1_SETZ_AT, 8'h01, 8'h00);
      xp(INS_SYS_WR);
      sw(SW_OK);
      cmd(INS_WR_USER, 8'h00, 8'h07, 8'h01);
      xp(INS_WR_USER);
      host.send(8'h55);
      sw(SW_OK);
      chk8("mem_at", 8'h01, 8'(atq[0]));
      chkw('{1'b0, 4'h1, 16'h0007, 8'h55}, wq[0]);
   endtask
   task automatic t_write();
      logic [7:0] d[4] = '{8'h04, 8'h09, 8'h19, 8'h97};
      time t0;
      cmd(INS_SYS_WR, P1_SETZONE, 8'h03, 8'h00);
      xp(INS_SYS_WR);
      sw(SW_OK);
      cmd(INS_WR_USER, 8'h00, 8'h02, 8'h04);
      xp(INS_WR_USER);
      foreach (d[i]) host.send(d[i]);
      t0 = $time;
      sw(SW_OK);
      chk8("cycle", 8'h01, 8'($time - t0 >= 100));
      chk8("writes", 8'h04, 8'(wq.size()));
      foreach (d[i]) chkw('{1'b0, 4'h3, 16'(i + 2), d[i]}, wq[i]);
      chk8("mem_at", 8'h00, 8'(atq[0]));
      chk8("zone", 8'h03, 8'(zone));
   endtask
   task automatic t_deny();
      wrr = 1'b0;
      cmd(INS_WR_USER, 8'h00, 8'h00, 8'h02);
      sw(SW_UNAUTH);
      chk8("writes", 8'h00, 8'(wq.size()));
      wrr = 1'b1;
      rdr = 1'b0;
      cmd(INS_RD_USER, 8'h00, 8'h00, 8'h02);
      sw(SW_UNAUTH);
      rdr = 1'b1;
   endtask
   task automatic t_read();
      host.stall = 3;
      cmd(INS_RD_USER, 8'h00, 8'h0E, 8'h04);
      xp(INS_RD_USER);
      for (int i = 0; i < 4; i++) xp(8'hA5 ^ 8'((14 + i) % 16));
      sw(SW_OK);
      host.stall = 0;
   endtask
   task automatic t_cfg();
      cmd(INS_SYS_WR, P1_CFG, 8'h1E, 8'h04);
      xp(INS_SYS_WR);
      repeat (4) host.send(8'h11);
      sw(SW_UNAUTH);
      chk8("writes", 8'h00, 8'(wq.size()));
      cmd(INS_SYS_WR, P1_CFG, 8'h30, 8'h01);
      sw(SW_UNAUTH);
      cmd(INS_SYS_WR, P1_CFG_AT, 8'h04, 8'h02);
      xp(INS_SYS_WR);
      host.send(8'h3C);
      host.send(8'hC3);
      sw(SW_OK);
      chk8("mem_at", 8'h01, 8'(atq[0] & wq[0].cfg));
      cmd(INS_SYS_RD, P1_CFG, 8'h1E, 8'h04);
      xp(INS_SYS_RD);
      xp(8'hE1);
      xp(8'hE0);
      repeat (2) xp(FUSE_RESET);
      sw(SW_UNAUTH);
      lim = 9'h100;
      cmd(INS_SYS_RD, P1_CFG, 8'h00, 8'h00);
      xp(INS_SYS_RD);
      for (int i = 0; i < 256; i++) xp(i == 4 ? 8'h3C : i == 5 ? 8'hC3 : ~8'(i));
      sw(SW_OK);
   endtask
   task automatic rdfuse(logic [7:0] e);
      cmd(INS_SYS_RD, P1_FUSE, 8'h00, FUSE_LEN);
      xp(INS_SYS_RD);
      xp(e);
      sw(SW_OK);
   endtask
   task automatic t_fuse();
      logic [7:0] id[3] = '{FUSE_ID_FIRST, FUSE_ID_SECOND, FUSE_ID_THIRD};
      rdfuse(8'h0F);
      cmd(INS_SYS_WR, P1_FUSE, FUSE_ID_FIRST, 8'h00);
      sw(SW_UNAUTH);
      sec = 1'b1;
      cmd(INS_SYS_WR, P1_FUSE, FUSE_ID_SECOND, 8'h00);
      sw(SW_UNAUTH);
      foreach (id[i]) begin
         cmd(INS_SYS_WR, P1_FUSE, id[i], 8'h00);
         xp(INS_SYS_WR);
         sw(SW_OK);
      end
      rdfuse(8'h08);
      chk8("fuse_state", 8'h08, fuse);
   endtask
   task automatic t_cksum();
      au = 1'b1;
      for (int k = 0; k < 2; k++) begin
         ck = k[0];
         cmd(INS_WR_USER, 8'h00, 8'h00, 8'h01);
         xp(INS_WR_USER);
         host.send(8'h5A);
         sw(SW_WAIT_CK);
         cmd(INS_SYS_WR, P1_CKSUM, 8'h00, CK_LEN);
         xp(INS_SYS_WR);
         host.send(8'hAB);
         host.send(8'hCD);
         sw(k == 0 ? SW_UNAUTH : SW_OK);
         chk8("writes", 8'(k), 8'(wq.size()));
      end
      chk8("revokes", 8'h01, 8'(nrev));
      au = 1'b0;
      cmd(INS_SYS_RD, P1_CKSUM, 8'h00, CK_LEN);
      xp(INS_SYS_RD);
      xp(8'hAB);
      xp(8'hCD);
      sw(SW_OK);
      chk8("cksum_o", 8'hAB, cko[15:8]);
   endtask
   task automatic report_and_stop();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk_i);
      n_errors++;
      report_and_stop();
   end
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      {wrr, rdr, au, sec, ck} = 5'h18;
      lim = 9'h020;
      repeat (2) @(posedge clk_i);
      #1 rst_i = 1'b0;
      t_tear();
      t_write();
      t_deny();
      t_read();
      t_cfg();
      t_fuse();
      t_cksum();
      report_and_stop();
   end
endmodule
